// ### hhp_haptic.sv
module hhp_haptic #(
  parameter int unsigned PS_WAIT_CYC = hhp_pkg::PS_WAIT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire hhp_pkg::hhp_reg_req_t reg_req,
  output      logic [7:0]        reg_rdata,
  input  wire logic [7:0]        eng_duty,
  input  wire logic [7:0]        fader_duty,
  input  wire logic              ext_pwm_pin,
  input  wire logic              idle_req,
  output      hhp_pkg::hhp_leg_t bridge_out_a,
  output      hhp_pkg::hhp_leg_t bridge_out_b,
  output      logic              group_pwm,
  output      logic              haptic_active,
  output      logic              ps_allow,
  output      logic              boost_cv_force,
  output      logic              boost_sel_5v0
);

  hhp_pkg::hhp_state_t s_q;
  hhp_pkg::hhp_state_t s_d;

  // Leg driven high: high-side on, low-side off.
  localparam hhp_pkg::hhp_leg_t LEG_HIGH = '{hi: 1'b1, lo: 1'b0};
  localparam hhp_pkg::hhp_leg_t LEG_LOW  = '{hi: 1'b0, lo: 1'b1};
  localparam hhp_pkg::hhp_leg_t LEG_OFF  = '{hi: 1'b0, lo: 1'b0};

  function automatic hhp_pkg::hhp_leg_t leg_of(input logic level);
    leg_of = level ? LEG_HIGH : LEG_LOW;
  endfunction : leg_of

  function automatic logic mode_dual(input hhp_pkg::hhp_mode_t m);
    mode_dual = (m == hhp_pkg::MODE_DUAL) ||
                (m == hhp_pkg::MODE_DUAL_QUIET);
  endfunction : mode_dual

  function automatic logic mode_on(input hhp_pkg::hhp_mode_t m);
    mode_on = (m != hhp_pkg::MODE_OFF0) && (m != hhp_pkg::MODE_OFF4);
  endfunction : mode_on

  // Reload value of the step prescaler; dual modes halve it.
  function automatic logic [9:0] div_load(input logic [1:0] f,
                                          input logic dual);
    logic [9:0] d;
    d = hhp_pkg::DIV0;
    case (f)
      2'h0:    d = hhp_pkg::DIV0;
      2'h1:    d = hhp_pkg::DIV1;
      2'h2:    d = hhp_pkg::DIV2;
      default: d = hhp_pkg::DIV3;
    endcase
    if (dual) begin
      d = d >> 1;
    end
    div_load = d - 10'h001;
  endfunction : div_load

  hhp_pkg::hhp_mode_t mode;
  logic [1:0]         freq;
  logic [1:0]         src;
  logic [7:0]         duty_src;
  logic               tick;
  logic               wrap;
  logic               cmp;
  logic               active;

  localparam int unsigned PS_CNT_W = hhp_pkg::PS_CNT_W;

  assign mode   = hhp_pkg::hhp_mode_t'(s_q.ctrl[hhp_pkg::CTRL_MODE_LSB +: 3]);
  assign freq   = s_q.ctrl[hhp_pkg::CTRL_FREQ_LSB +: 2];
  assign src    = s_q.ctrl[hhp_pkg::CTRL_SRC_LSB +: 2];
  assign active = mode_on(mode);
  assign tick   = (s_q.div_cnt == 10'h000);
  assign wrap   = tick && (s_q.pwm_cnt == hhp_pkg::DUTY_FULL);

  // Engines and the fader only ever supply duty; the mode field has no
  // path from them, so only a register write can change the mode.
  always_comb begin
    case (src)
      hhp_pkg::SRC_ENG:   duty_src = eng_duty;
      hhp_pkg::SRC_FADER: duty_src = fader_duty;
      default:            duty_src = s_q.duty;
    endcase
  end

  // FFH is stretched to a full period so the leg is truly always on.
  assign cmp = (s_q.duty_act == hhp_pkg::DUTY_FULL) ||
               (s_q.pwm_cnt < s_q.duty_act);

  always_comb begin
    s_d = s_q;

    s_d.ext_s1 = ext_pwm_pin;
    s_d.ext_s2 = s_q.ext_s1;

    if (reg_req.wr) begin
      case (reg_req.addr)
        hhp_pkg::ADDR_CTRL: s_d.ctrl = reg_req.wdata;
        hhp_pkg::ADDR_DUTY: s_d.duty = reg_req.wdata;
        hhp_pkg::ADDR_MISC: s_d.misc = reg_req.wdata;
        default:            s_d.misc = s_q.misc;
      endcase
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        hhp_pkg::ADDR_CTRL: s_d.rdata = s_q.ctrl;
        hhp_pkg::ADDR_DUTY: s_d.rdata = s_q.duty_act;
        hhp_pkg::ADDR_MISC: s_d.rdata = s_q.misc;
        default:            s_d.rdata = 8'h00;
      endcase
    end

    // Prescaler and free-running step counter.
    if (tick) begin
      s_d.div_cnt = div_load(freq, mode_dual(mode));
      s_d.pwm_cnt = 8'(s_q.pwm_cnt + 8'h01);
    end else begin
      s_d.div_cnt = s_q.div_cnt - 10'h001;
    end

    // New duty takes effect only at a period boundary, which keeps
    // every pulse whole at the cost of up to one period of latency.
    if (wrap) begin
      s_d.duty_act = duty_src;
    end

    // Leg encoding follows the bridge truth table.
    case (mode)
      hhp_pkg::MODE_DUAL: begin
        s_d.leg_a = leg_of(cmp);
        s_d.leg_b = leg_of(!cmp);
      end
      hhp_pkg::MODE_DUAL_QUIET: begin
        if (s_q.duty_act == hhp_pkg::DUTY_CENTER) begin
          s_d.leg_a = LEG_OFF;
          s_d.leg_b = LEG_OFF;
        end else begin
          s_d.leg_a = leg_of(cmp);
          s_d.leg_b = leg_of(!cmp);
        end
      end
      hhp_pkg::MODE_A_B_LOW: begin
        s_d.leg_a = leg_of(cmp);
        s_d.leg_b = LEG_LOW;
      end
      hhp_pkg::MODE_B_A_LOW: begin
        s_d.leg_a = LEG_LOW;
        s_d.leg_b = leg_of(cmp);
      end
      hhp_pkg::MODE_A_B_HIGH: begin
        s_d.leg_a = leg_of(cmp);
        s_d.leg_b = LEG_HIGH;
      end
      hhp_pkg::MODE_B_A_HIGH: begin
        s_d.leg_a = LEG_HIGH;
        s_d.leg_b = leg_of(cmp);
      end
      default: begin
        s_d.leg_a = LEG_OFF;
        s_d.leg_b = LEG_OFF;
      end
    endcase

    // Select bit low hands the group dimmer the haptic waveform.
    if (s_q.misc[hhp_pkg::MISC_SEL_BIT]) begin
      s_d.grp_pwm = s_q.ext_s2;
    end else begin
      s_d.grp_pwm = cmp;
    end

    s_d.boost_cv  = active;
    s_d.boost_5v0 = s_q.ctrl[hhp_pkg::CTRL_VSEL_BIT];

    // Power-save gate: a haptic run must sit out the settle time so the
    // motor is at rest before the supply drops.
    case (s_q.ps)
      hhp_pkg::PS_RUN: begin
        s_d.ps_ok  = 1'b0;
        s_d.ps_cnt = '0;
        if (idle_req) begin
          if (active) begin
            s_d.ps = hhp_pkg::PS_WAIT;
          end else begin
            s_d.ps    = hhp_pkg::PS_READY;
            s_d.ps_ok = 1'b1;
          end
        end
      end
      hhp_pkg::PS_WAIT: begin
        if (!idle_req) begin
          s_d.ps = hhp_pkg::PS_RUN;
        end else if (s_q.ps_cnt == PS_CNT_W'(PS_WAIT_CYC - 1)) begin
          s_d.ps    = hhp_pkg::PS_READY;
          s_d.ps_ok = 1'b1;
        end else begin
          s_d.ps_cnt = s_q.ps_cnt + PS_CNT_W'(1);
        end
      end
      hhp_pkg::PS_READY: begin
        if (!idle_req) begin
          s_d.ps    = hhp_pkg::PS_RUN;
          s_d.ps_ok = 1'b0;
        end
      end
      default: begin
        s_d.ps    = hhp_pkg::PS_RUN;
        s_d.ps_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0;
      s_q.ctrl      <= hhp_pkg::CTRL_RST;
      s_q.duty      <= hhp_pkg::DUTY_RST;
      s_q.duty_act  <= hhp_pkg::DUTY_RST;
      s_q.misc      <= hhp_pkg::MISC_RST;
      s_q.ps        <= hhp_pkg::PS_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata      = s_q.rdata;
  assign bridge_out_a   = s_q.leg_a;
  assign bridge_out_b   = s_q.leg_b;
  assign group_pwm      = s_q.grp_pwm;
  assign haptic_active  = s_q.boost_cv;
  assign ps_allow       = s_q.ps_ok;
  assign boost_cv_force = s_q.boost_cv;
  assign boost_sel_5v0  = s_q.boost_5v0;

endmodule : hhp_haptic

// ### hhp_haptic_assertions.sv
module hhp_haptic_checker #(
  parameter int unsigned PS_WAIT_CYC = 20
) (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire hhp_pkg::hhp_reg_req_t reg_req,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  idle_req,
  input wire hhp_pkg::hhp_leg_t     bridge_out_a,
  input wire hhp_pkg::hhp_leg_t     bridge_out_b,
  input wire logic                  haptic_active,
  input wire logic                  ps_allow,
  input wire logic                  boost_cv_force,
  input wire logic                  boost_sel_5v0
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [24:0] idle_q;
  // Counts consecutive idle requests so the long wait needs no repetition.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idle_q <= '0;
    else idle_q <= idle_req ? idle_q + 25'h1 : '0;
  end
  property p_off;
    !haptic_active && !$past(haptic_active)
      |-> {bridge_out_a, bridge_out_b} == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("legs active in off mode");
  // The forced boost mode must follow the mode written, not merely mirror.
  property p_cv;
    reg_req.wr && reg_req.addr == hhp_pkg::ADDR_CTRL |-> ##2
      (boost_cv_force == haptic_active) &&
      (haptic_active !=
       ($past(reg_req.wdata[2:0], 2) inside {3'h0, 3'h4}));
  endproperty
  a_cv: assert property (p_cv) else $error("boost mode not forced");
  property p_leg;
    !(bridge_out_a.hi && bridge_out_a.lo) && !(bridge_out_b.hi && bridge_out_b.lo);
  endproperty
  a_leg: assert property (p_leg) else $error("leg shoot-through");
  property p_ps_drop;
    !idle_req |=> !ps_allow;
  endproperty
  a_ps_drop: assert property (p_ps_drop) else $error("ps_allow kept");
  property p_ps_wait;
    ps_allow && haptic_active |-> idle_q >= PS_WAIT_CYC;
  endproperty
  a_ps_wait: assert property (p_ps_wait) else $error("ps_allow early");
  property p_ps_quick;
    (idle_req && !haptic_active) [*4] |-> ps_allow;
  endproperty
  a_ps_quick: assert property (p_ps_quick) else $error("ps_allow late");
  property p_rd_mode;
    reg_req.rd && !reg_req.wr && reg_req.addr == hhp_pkg::ADDR_CTRL
      |-> ##2 (reg_rdata[2:0] inside {3'h0, 3'h4}) != haptic_active;
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode vs active");
  property p_vsel;
    $changed(boost_sel_5v0) |-> $past(reg_req.wr) || $past(reg_req.wr, 2);
  endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select moved");
  c_ps: cover property (haptic_active && $rose(ps_allow));
  c_a: cover property (haptic_active && $rose(bridge_out_a.hi));
  c_rd: cover property (reg_req.rd);
endmodule : hhp_haptic_checker

bind hhp_haptic hhp_haptic_checker #(.PS_WAIT_CYC(PS_WAIT_CYC)) chk_inst (
  .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .idle_req(idle_req), .bridge_out_a(bridge_out_a),
  .bridge_out_b(bridge_out_b), .haptic_active(haptic_active),
  .ps_allow(ps_allow), .boost_cv_force(boost_cv_force),
  .boost_sel_5v0(boost_sel_5v0));

// ### hhp_haptic_tb_top.sv
module hhp_haptic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned W = 20;
  localparam logic [7:0] KT [8] = '{8'h00, 8'h69, 8'h4B, 8'h1E,
                                     8'h00, 8'h69, 8'h78, 8'hD2};
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  hhp_pkg::hhp_reg_req_t req = '0;
  hhp_pkg::hhp_leg_t     la, lb;
  logic [7:0]            rdata, dv [4];
  logic [7:0]            eng = 8'h00, fad = 8'h00;
  logic [1:0]            mot;
  logic                  ext = 1'b0, idle = 1'b0;
  logic                  gp, act, psa, cv, v5, flt;
  int                    err_count = 0, checks_done = 0;
  int                    ah, bh, al, bl, gh, br, s;
  always #20 clk = ~clk;
  hhp_haptic #(.PS_WAIT_CYC(W)) hhp_haptic_inst (.clk(clk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .eng_duty(eng), .fader_duty(fad),
    .ext_pwm_pin(ext), .idle_req(idle), .bridge_out_a(la),
    .bridge_out_b(lb), .group_pwm(gp), .haptic_active(act),
    .ps_allow(psa), .boost_cv_force(cv), .boost_sel_5v0(v5));
  hhp_motor_model hhp_motor_model_inst (.clk(clk), .rst_n(rst_n),
    .bridge_out_a(la), .bridge_out_b(lb), .motion(mot), .fault(flt));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  function automatic int ex(input logic [1:0] k, input int d, input int p);
    case (k)
      2'h0: return 0;
      2'h1: return d;
      2'h2: return p - d;
      default: return p;
    endcase
  endfunction : ex
  // Any window of exactly one period holds the same number of on-steps.
  task automatic mode_chk(input logic [7:0] c, input logic [7:0] k,
                          input int d, input int s);
    int p;
    p = 256 * s;
    wr(hhp_pkg::ADDR_CTRL, c);
    wait_n(100);
    {ah, bh, al, bl, gh, br} = '0;
    repeat (p) begin
      @(negedge clk);
      ah += int'(la === 2'b10);
      bh += int'(lb === 2'b10);
      al += int'(la === 2'b01);
      bl += int'(lb === 2'b01);
      gh += int'(gp === 1'b1);
      br += int'(mot === 2'h3);
    end
    chk(ah, ex(k[7:6], d, p));
    chk(bh, ex(k[5:4], d, p));
    chk(al, ex(k[3:2], d, p));
    chk(bl, ex(k[1:0], d, p));
  endtask : mode_chk
  initial begin
    repeat (99000) @(negedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    dv = '{8'h00, 8'h80, 8'h80, 8'hFF};
    wait_n(8);
    rst_n = 1'b1;
    rd(hhp_pkg::ADDR_CTRL, 8'h00);
    rd(hhp_pkg::ADDR_DUTY, 8'h00);
    rd(hhp_pkg::ADDR_MISC, 8'h02);
    rd(8'h40, 8'h00);
    chk({la, lb, act, cv, psa}, 7'h00);
    wr(hhp_pkg::ADDR_CTRL, 8'h19);
    wr(hhp_pkg::ADDR_DUTY, 8'h40);
    wr(hhp_pkg::ADDR_MISC, 8'h00);
    rd(hhp_pkg::ADDR_MISC, 8'h00);
    // The first step after reset runs at the slowest rate, so the first
    // period boundary comes late.
    wait_n(3700);
    rd(hhp_pkg::ADDR_DUTY, 8'h40);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      s = (m % 4 == 1) ? int'(hhp_pkg::DIV3) / 2 : int'(hhp_pkg::DIV3);
      mode_chk(8'h18 | 8'(m), KT[m], 64 * s, s);
      if (m == 2) chk(gh, 64 * s);
      if (m == 6) chk(br, 64 * s);
    end
    $display("test modes done");
    s = int'(hhp_pkg::DIV3) / 2;
    // A short period first, so each new duty is applied within the wait.
    wr(hhp_pkg::ADDR_CTRL, 8'h19);
    for (int i = 0; i < 4; i++) begin
      wr(hhp_pkg::ADDR_DUTY, dv[i]);
      wait_n(3100);
      mode_chk(i == 2 ? 8'h1D : 8'h19, i == 2 ? 8'h00 : 8'h69,
               i == 3 ? 256 * s : int'(dv[i]) * s, s);
    end
    wr(hhp_pkg::ADDR_DUTY, 8'h40);
    wait_n(3100);
    s = int'(hhp_pkg::DIV2) / 2;
    mode_chk(8'h11, 8'h69, 64 * s, s);
    $display("test duty and frequency done");
    eng = 8'h33;
    fad = 8'h5A;
    wr(hhp_pkg::ADDR_CTRL, 8'h39);
    wait_n(3200);
    rd(hhp_pkg::ADDR_DUTY, 8'h33);
    wr(hhp_pkg::ADDR_CTRL, 8'h59);
    wait_n(3200);
    rd(hhp_pkg::ADDR_DUTY, 8'h5A);
    rd(hhp_pkg::ADDR_CTRL, 8'h59);
    $display("test sources done");
    wr(hhp_pkg::ADDR_CTRL, 8'h00);
    idle = 1'b1;
    wait_n(6);
    chk(psa, 1'b1);
    idle = 1'b0;
    wait_n(2);
    chk(psa, 1'b0);
    wr(hhp_pkg::ADDR_CTRL, 8'h9A);
    wait_n(3);
    chk({cv, v5}, 2'h3);
    idle = 1'b1;
    wait_n(W - 4);
    chk(psa, 1'b0);
    wait_n(8);
    chk(psa, 1'b1);
    idle = 1'b0;
    $display("test power-save done");
    wr(hhp_pkg::ADDR_MISC, 8'h02);
    ext = 1'b1;
    wait_n(6);
    chk(gp, 1'b1);
    ext = 1'b0;
    wait_n(6);
    chk(gp, 1'b0);
    chk(flt, 1'b0);
    rst_n = 1'b0;
    wait_n(8);
    rst_n = 1'b1;
    rd(hhp_pkg::ADDR_CTRL, 8'h00);
    $display("test group input and reset done");
    end_sim();
  end
endmodule : hhp_haptic_tb_top

// ### hhp_motor_model.sv
module hhp_motor_model (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire hhp_pkg::hhp_leg_t bridge_out_a,
  input wire hhp_pkg::hhp_leg_t bridge_out_b,
  output     logic [1:0]        motion,
  output     logic              fault
);
  timeunit 1ns;
  timeprecision 1ns;
  // Motion: 1 clockwise, 2 counter-clockwise, 3 brake, 0 coasting.
  always_comb begin
    case ({bridge_out_a, bridge_out_b})
      4'h9: motion = 2'h1;
      4'h6: motion = 2'h2;
      4'hA, 4'h5: motion = 2'h3;
      default: motion = 2'h0;
    endcase
  end
  // Both switches of one leg on would short the supply, so it latches.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fault <= 1'b0;
    else if (&bridge_out_a || &bridge_out_b) fault <= 1'b1;
  end
endmodule : hhp_motor_model

// ### hhp_pkg.sv
// Notes on behaviour
// - Two-bit field picks 157/490/980/3900 Hz.
// - Duty held and applied at eight bits.
// - Modes 000 and 100 keep bridge idle.
// - Modes 001/101 complementary at doubled frequency.
// - 00H drives B only; FFH drives A only.
// - 80H gives equal pulses, motor stands.
// - Mode 101 idles both channels at 80H.
// - Mode 010 modulates A, B held low.
// - Mode 011 modulates B, A held low.
// - Mode 110 modulates A, B held high.
// - Mode 111 modulates B, A held high.
// - High/low switch pairs set direction or brake.
// - Duty from register, engine or group fader.
// - Engines set duty only; mode is register-only.
// - Clearing select bit routes haptic to group PWM.
// - One second wait before power-save in haptic.
// - Haptic forces boost constant voltage, 4.5/5.0V.
package hhp_pkg;

  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned PWM_STEPS = 256;
  localparam int unsigned FREQ0_HZ  = 157;
  localparam int unsigned FREQ1_HZ  = 490;
  localparam int unsigned FREQ2_HZ  = 980;
  localparam int unsigned FREQ3_HZ  = 3900;
  localparam int unsigned DIV_W     = 10;

  // Clocks per counter step; integer division rounds down, so a step is never longer than nominal.
  localparam logic [9:0] DIV0 = 10'(CLK_HZ / (FREQ0_HZ * PWM_STEPS));
  localparam logic [9:0] DIV1 = 10'(CLK_HZ / (FREQ1_HZ * PWM_STEPS));
  localparam logic [9:0] DIV2 = 10'(CLK_HZ / (FREQ2_HZ * PWM_STEPS));
  localparam logic [9:0] DIV3 = 10'(CLK_HZ / (FREQ3_HZ * PWM_STEPS));

  localparam int unsigned PS_WAIT_MS  = 1000;
  localparam int unsigned PS_WAIT_CYC = (CLK_HZ / 1000) * PS_WAIT_MS;
  localparam int unsigned PS_CNT_W    = 25;

  localparam logic [7:0] ADDR_CTRL = 8'h21;
  localparam logic [7:0] ADDR_DUTY = 8'h22;
  localparam logic [7:0] ADDR_MISC = 8'h36;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_FREQ_LSB = 3;
  localparam int unsigned CTRL_SRC_LSB  = 5;
  localparam int unsigned CTRL_VSEL_BIT = 7;
  localparam int unsigned MISC_SEL_BIT  = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] MISC_RST = 8'h02;

  localparam logic [7:0] DUTY_ZERO   = 8'h00;
  localparam logic [7:0] DUTY_CENTER = 8'h80;
  localparam logic [7:0] DUTY_FULL   = 8'hFF;

  localparam logic [1:0] SRC_REG   = 2'h0;
  localparam logic [1:0] SRC_ENG   = 2'h1;
  localparam logic [1:0] SRC_FADER = 2'h2;

  typedef enum logic [2:0] {
    MODE_OFF0       = 3'h0,
    MODE_DUAL       = 3'h1,
    MODE_A_B_LOW    = 3'h2,
    MODE_B_A_LOW    = 3'h3,
    MODE_OFF4       = 3'h4,
    MODE_DUAL_QUIET = 3'h5,
    MODE_A_B_HIGH   = 3'h6,
    MODE_B_A_HIGH   = 3'h7
  } hhp_mode_t;

  typedef enum logic [2:0] {
    PS_RUN   = 3'h1,
    PS_WAIT  = 3'h2,
    PS_READY = 3'h4
  } hhp_ps_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hhp_reg_req_t;

  // One bridge leg: hi is the high-side switch, lo the low-side one.
  typedef struct packed {
    logic hi;
    logic lo;
  } hhp_leg_t;

  typedef struct packed {
    logic [7:0]          ctrl;
    logic [7:0]          duty;
    logic [7:0]          misc;
    logic [7:0]          rdata;
    logic [9:0]          div_cnt;
    logic [7:0]          pwm_cnt;
    logic [7:0]          duty_act;
    hhp_leg_t            leg_a;
    hhp_leg_t            leg_b;
    logic                grp_pwm;
    logic                ext_s1;
    logic                ext_s2;
    hhp_ps_t             ps;
    logic [24:0]         ps_cnt;
    logic                ps_ok;
    logic                boost_cv;
    logic                boost_5v0;
  } hhp_state_t;

endpackage : hhp_pkg
